// >>> hw/srpf_framer.sv
// serial receive packet framer: buffers received bytes and closes packets
// assumes rx bytes, settings and link status come from logic on ref_clk
// What this block does
// - zero size limit: close on match or full
// - nonzero limit: close when count reaches limit
// - single match: close on that byte value
// - dual match: first then second closes
// - with match on, accumulate until match/full
// - match policy ignored when first match off
// - keep policy: close, delimiters kept
// - plus-one policy: one more byte, then close
// - plus-two policy: two more bytes, then close
// - strip policy: close, delimiters removed
// - zero idle timeout never closes
// - idle gap of timeout ms closes packet
// - low policy: selected line low on link loss
// - high policy: selected line high on link loss
`timescale 1ns/1ns
`include "srpf_map.svh"

module srpf_framer #(
    parameter int DEPTH     = `SRPF_BUF_DEPTH,  // buffer size in bytes
    parameter int MS_CYCLES = `SRPF_MS_CYCLES   // cycles per millisecond
) (
    input  wire logic                     ref_clk,
    input  wire logic                     srst,
    input  wire logic                     rx_valid,        // serial byte offered
    input  wire logic [7:0]               rx_data,         // serial byte
    output logic                          rx_ready,        // byte taken this cycle
    input  wire logic [`SRPF_SIZE_W-1:0]  size_limit,      // 0 = off, 1..1024
    input  wire logic                     match1_en,       // first match on
    input  wire logic [7:0]               match1_val,      // first match byte
    input  wire logic                     match2_en,       // second match on
    input  wire logic [7:0]               match2_val,      // second match byte
    input  wire srpf_pkg::srpf_policy_t   match_policy,    // delimiter handling
    input  wire logic [`SRPF_TMO_W-1:0]   idle_timeout_ms, // 0 = never
    output logic                          pkt_valid,       // packet byte offered
    output logic [7:0]                    pkt_data,        // packet byte
    output logic                          pkt_last,        // last byte of packet
    input  wire logic                     pkt_ready,       // network path takes it
    input  wire logic                     link_up,         // network connection up
    input  wire logic                     linkloss_high,   // 1 = hold high on loss
    input  wire logic                     linkloss_sel_dtr,// 0 = rts, 1 = dtr
    input  wire logic                     rts_req,         // wanted rts level
    input  wire logic                     dtr_req,         // wanted dtr level
    output logic                          rts_out,         // rts line level
    output logic                          dtr_out          // dtr line level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [7:0]            mem [0:DEPTH-1];          // packet buffer
    srpf_pkg::srpf_state_t state_r, state_nxt;       // fill or send
    logic [CW-1:0]         cnt_r,   cnt_nxt;         // bytes buffered
    logic [CW-1:0]         len_r,   len_nxt;         // length of closed packet
    logic [CW-1:0]         rd_r,    rd_nxt;          // next byte to hand out
    logic                  prev_r,  prev_nxt;        // last byte hit first match
    logic [1:0]            trail_r, trail_nxt;       // trailing bytes still due
    logic                  vld_r,   vld_nxt;         // output byte held
    logic [7:0]            dat_r,   dat_nxt;         // output byte
    logic                  last_r,  last_nxt;        // output byte is the last
    logic                  rts_r,   rts_nxt;         // rts line
    logic                  dtr_r,   dtr_nxt;         // dtr line
    logic                  take;                     // byte accepted
    logic                  hit_one;                  // byte equals first match
    logic                  seq_hit;                  // match sequence complete
    logic                  close;                    // packet closes this cycle
    logic [CW-1:0]         cnt_inc;                  // count with this byte
    logic [CW-1:0]         strip_n;                  // delimiters to drop

    srpf_tmr_if tmr ();

    srpf_idle_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_idle (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tmr     (tmr)
    );

    assign rx_ready       = (state_r == srpf_pkg::SRPF_FILL);
    assign take           = rx_valid && rx_ready;
    assign pkt_valid      = vld_r;
    assign pkt_data       = dat_r;
    assign pkt_last       = last_r;
    assign rts_out        = rts_r;
    assign dtr_out        = dtr_r;
    assign tmr.restart    = take;
    assign tmr.clear      = close;
    assign tmr.timeout_ms = idle_timeout_ms;

    // ------------------------------------------------------------------------
    // gathering, closing and handing out
    // ------------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        len_nxt   = len_r;
        rd_nxt    = rd_r;
        prev_nxt  = prev_r;
        trail_nxt = trail_r;
        vld_nxt   = vld_r;
        dat_nxt   = dat_r;
        last_nxt  = last_r;
        close     = 1'b0;
        strip_n   = '0;
        cnt_inc   = cnt_r + 1'b1;
        hit_one   = match1_en && (rx_data == match1_val);
        // second match counts only straight after the first
        seq_hit   = match2_en ? (match1_en && prev_r && (rx_data == match2_val))
                              : hit_one;
        if (take)
        begin
            cnt_nxt  = cnt_inc;
            prev_nxt = hit_one;
            // buffer full always closes
            if (cnt_inc == CW'(DEPTH))
                close = 1'b1;
            // size limit closes when reached
            if ((size_limit != '0) && (cnt_inc == CW'(size_limit)))
                close = 1'b1;
            if (trail_r != 2'h0)
            begin
                // trailing bytes after a match
                trail_nxt = trail_r - 2'h1;
                if (trail_r == 2'h1)
                    close = 1'b1;
            end
            else if (seq_hit)
            begin
                // policy only matters with first match on
                case (match_policy)
                    srpf_pkg::SRPF_KEEP:  close = 1'b1;
                    srpf_pkg::SRPF_PLUS1: trail_nxt = 2'h1;
                    srpf_pkg::SRPF_PLUS2: trail_nxt = 2'h2;
                    srpf_pkg::SRPF_STRIP:
                    begin
                        // drop one or both delimiters from the length
                        close   = 1'b1;
                        strip_n = match2_en ? CW'(2) : CW'(1);
                    end
                    default:              close = 1'b1;
                endcase
            end
            len_nxt = cnt_inc - strip_n;
        end
        else if (tmr.expired && rx_ready && (cnt_r != '0))
        begin
            // idle gap flushes what is buffered
            close   = 1'b1;
            len_nxt = cnt_r;
        end
        if (close)
        begin
            // at most one packet per close, next starts empty
            cnt_nxt   = '0;
            prev_nxt  = 1'b0;
            trail_nxt = 2'h0;
            rd_nxt    = '0;
            state_nxt = (len_nxt != '0) ? srpf_pkg::SRPF_SEND : srpf_pkg::SRPF_FILL;
        end
        else if (!take)
        begin
            len_nxt = len_r;
        end
        if (state_r == srpf_pkg::SRPF_SEND)
        begin
            if (!vld_r || pkt_ready)
            begin
                if (rd_r < len_r)
                begin
                    // present the next buffered byte
                    vld_nxt  = 1'b1;
                    dat_nxt  = mem[rd_r[AW-1:0]];
                    last_nxt = (rd_r == len_r - 1'b1);
                    rd_nxt   = rd_r + 1'b1;
                end
                else
                begin
                    // packet fully taken, resume gathering
                    vld_nxt   = 1'b0;
                    last_nxt  = 1'b0;
                    state_nxt = srpf_pkg::SRPF_FILL;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // link loss: force the selected modem line
    // ------------------------------------------------------------------------
    always_comb
    begin
        rts_nxt = rts_req;
        dtr_nxt = dtr_req;
        if (!link_up)
        begin
            // low or high by policy on the chosen line
            if (linkloss_sel_dtr)
                dtr_nxt = linkloss_high;
            else
                rts_nxt = linkloss_high;
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (take)
            mem[cnt_r[AW-1:0]] <= rx_data;
        if (srst)
        begin
            state_r <= srpf_pkg::SRPF_FILL;
            cnt_r   <= '0;
            len_r   <= '0;
            rd_r    <= '0;
            prev_r  <= 1'b0;
            trail_r <= 2'h0;
            vld_r   <= 1'b0;
            dat_r   <= 8'h00;
            last_r  <= 1'b0;
            rts_r   <= 1'b1;
            dtr_r   <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            len_r   <= len_nxt;
            rd_r    <= rd_nxt;
            prev_r  <= prev_nxt;
            trail_r <= trail_nxt;
            vld_r   <= vld_nxt;
            dat_r   <= dat_nxt;
            last_r  <= last_nxt;
            rts_r   <= rts_nxt;
            dtr_r   <= dtr_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    sequence s_take_size;
        take && (size_limit != '0) && (cnt_inc == CW'(size_limit));
    endsequence
    sequence s_dual_hit;
        take && match1_en && match2_en && prev_r && (rx_data == match2_val);
    endsequence

    a_size_closes: assert property (@(posedge ref_clk) disable iff (srst)
        s_take_size |=> (cnt_r == '0) && !rx_ready)
        else $error("size limit did not close the packet");
    a_full_closes: assert property (@(posedge ref_clk) disable iff (srst)
        take && (cnt_inc == CW'(DEPTH)) |=> (cnt_r == '0) && (len_r != '0))
        else $error("full buffer did not close");
    a_single_keep: assert property (@(posedge ref_clk) disable iff (srst)
        take && match1_en && !match2_en && (trail_r == 2'h0) && (rx_data == match1_val)
        && (match_policy == srpf_pkg::SRPF_KEEP) |=> (len_r == $past(cnt_inc)))
        else $error("single match keep length wrong");
    a_dual_strip: assert property (@(posedge ref_clk) disable iff (srst)
        (s_dual_hit and (trail_r == 2'h0) && (match_policy == srpf_pkg::SRPF_STRIP))
        |=> (len_r == $past(cnt_inc) - CW'(2)) && (cnt_r == '0))
        else $error("strip did not drop both delimiters");
    a_match_off_open: assert property (@(posedge ref_clk) disable iff (srst)
        take && !match1_en && (size_limit == '0) && (cnt_inc != CW'(DEPTH))
        && (trail_r == 2'h0) |=> (cnt_r == $past(cnt_inc)))
        else $error("closed with match and size off");
    a_plus_two_wait: assert property (@(posedge ref_clk) disable iff (srst)
        (trail_r == 2'h2) && take && (cnt_inc != CW'(DEPTH)) && (size_limit == '0)
        |=> (trail_r == 2'h1) && rx_ready)
        else $error("plus-two closed too early");
    a_plus_one_close: assert property (@(posedge ref_clk) disable iff (srst)
        (trail_r == 2'h1) && take |=> (cnt_r == '0) && (trail_r == 2'h0))
        else $error("plus-one did not close after one byte");
    a_idle_flush: assert property (@(posedge ref_clk) disable iff (srst)
        tmr.expired && !take && rx_ready && (cnt_r != '0)
        |=> (state_r == srpf_pkg::SRPF_SEND) && (len_r == $past(cnt_r)))
        else $error("idle expiry did not flush");
    a_link_low: assert property (@(posedge ref_clk) disable iff (srst)
        !link_up && !linkloss_high
        |=> ($past(linkloss_sel_dtr) ? !dtr_out : !rts_out))
        else $error("selected line not low on link loss");
    a_link_high: assert property (@(posedge ref_clk) disable iff (srst)
        !link_up && linkloss_high
        |=> ($past(linkloss_sel_dtr) ? dtr_out : rts_out))
        else $error("selected line not high on link loss");
    a_one_packet: assert property (@(posedge ref_clk) disable iff (srst)
        pkt_valid && pkt_ready && pkt_last |=> !pkt_valid)
        else $error("extra byte after packet end");
endmodule

// >>> hw/srpf_map.svh
// constants of the serial receive packet framer: sizes, timing, policy codes
// assumes the includer is a synthesizable module, interface or package on a 125 MHz clock
`ifndef SRPF_MAP_SVH
`define SRPF_MAP_SVH

// ----------------------------------------------------------------------------
// buffer and setting widths
// ----------------------------------------------------------------------------
`define SRPF_BUF_DEPTH      1024
`define SRPF_SIZE_W         11
`define SRPF_TMO_W          16

// ----------------------------------------------------------------------------
// timing: clock period and one millisecond, both in ns
// ----------------------------------------------------------------------------
`define SRPF_CLK_PERIOD_NS  8
`define SRPF_MS_NS          1000000
`define SRPF_MS_CYCLES      (`SRPF_MS_NS / `SRPF_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// match policy codes and state codes
// ----------------------------------------------------------------------------
`define SRPF_POL_KEEP       2'h0
`define SRPF_POL_PLUS1      2'h1
`define SRPF_POL_PLUS2      2'h2
`define SRPF_POL_STRIP      2'h3
`define SRPF_ST_FILL        1'h0
`define SRPF_ST_SEND        1'h1

`endif

// >>> hw/srpf_pkg.sv
// types shared by the packet framer modules
// assumes srpf_map.svh is on the include path
`include "srpf_map.svh"

package srpf_pkg;
    // how a matched delimiter sequence closes a packet
    typedef enum logic [1:0] {
        SRPF_KEEP  = `SRPF_POL_KEEP,
        SRPF_PLUS1 = `SRPF_POL_PLUS1,
        SRPF_PLUS2 = `SRPF_POL_PLUS2,
        SRPF_STRIP = `SRPF_POL_STRIP
    } srpf_policy_t;

    // framer state: gathering bytes or handing a closed packet out
    typedef enum logic {
        SRPF_FILL = `SRPF_ST_FILL,
        SRPF_SEND = `SRPF_ST_SEND
    } srpf_state_t;
endpackage

// >>> hw/srpf_tmr_if.sv
// carrier between the framer and its idle timer
// assumes both ends run on the same ref_clk
`timescale 1ns/1ns
`include "srpf_map.svh"

interface srpf_tmr_if;
    logic                     restart;     // a byte arrived, start timing anew
    logic                     clear;       // a packet closed, stop timing
    logic [`SRPF_TMO_W-1:0]   timeout_ms;  // idle limit in ms, 0 = never
    logic                     expired;     // one-cycle pulse: idle limit reached

    modport timer (input restart, input clear, input timeout_ms, output expired);
    modport user  (output restart, output clear, output timeout_ms, input expired);
endinterface

// >>> hw/srpf_idle_timer.sv
// idle flush timer: counts whole milliseconds since the last received byte
// assumes restart and clear come from logic on ref_clk
`timescale 1ns/1ns
`include "srpf_map.svh"

module srpf_idle_timer #(
    parameter int MS_CYCLES = `SRPF_MS_CYCLES  // clock cycles in one millisecond
) (
    input  wire logic   ref_clk,
    input  wire logic   srst,
    srpf_tmr_if.timer   tmr
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [31:0]              pre_r,   pre_nxt;    // cycles inside current ms
    logic [`SRPF_TMO_W-1:0]   ms_r,    ms_nxt;     // whole ms elapsed
    logic                     armed_r, armed_nxt;  // timing a gap
    logic                     exp_r,   exp_nxt;    // expiry pulse

    assign tmr.expired = exp_r;

    // ------------------------------------------------------------------------
    // next values
    // ------------------------------------------------------------------------
    always_comb
    begin
        pre_nxt   = pre_r;
        ms_nxt    = ms_r;
        armed_nxt = armed_r;
        exp_nxt   = 1'b0;
        if (tmr.clear)
        begin
            // a closed packet leaves nothing to flush, even when a byte closed it
            armed_nxt = 1'b0;
        end
        else if (tmr.restart)
        begin
            // each byte starts a fresh gap
            pre_nxt   = 32'h0000_0000;
            ms_nxt    = '0;
            armed_nxt = (tmr.timeout_ms != '0);  // zero never times out
        end
        else if (armed_r)
        begin
            if (pre_r == 32'(MS_CYCLES - 1))
            begin
                pre_nxt = 32'h0000_0000;
                ms_nxt  = ms_r + 1'b1;
                if (ms_r + 1'b1 == tmr.timeout_ms)
                begin
                    // gap reached the limit: fire once
                    exp_nxt   = 1'b1;
                    armed_nxt = 1'b0;
                end
            end
            else
            begin
                pre_nxt = pre_r + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pre_r   <= 32'h0000_0000;
            ms_r    <= '0;
            armed_r <= 1'b0;
            exp_r   <= 1'b0;
        end
        else
        begin
            pre_r   <= pre_nxt;
            ms_r    <= ms_nxt;
            armed_r <= armed_nxt;
            exp_r   <= exp_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_zero_never_fires: assert property (@(posedge ref_clk) disable iff (srst)
        (tmr.timeout_ms == '0) && $stable(tmr.timeout_ms) |-> !exp_nxt)
        else $error("idle timer fired with zero timeout");
    a_restart_disarms_exp: assert property (@(posedge ref_clk) disable iff (srst)
        tmr.restart |=> !exp_r)
        else $error("idle timer fired right after a byte");
endmodule

// >>> bench/srpf_net_sink.sv
// network transmit path model: takes packet bytes, can stall, logs each byte
// assumes the framer's packet outputs are registered on ref_clk
`timescale 1ns/1ns

module srpf_net_sink (
    input  wire logic       ref_clk,
    input  wire logic       slow,       // 1 = accept only every other cycle
    input  wire logic       pkt_valid,  // packet byte offered
    input  wire logic [7:0] pkt_data,   // packet byte
    input  wire logic       pkt_last,   // last byte of packet
    output logic            pkt_ready   // byte accepted this cycle
);
    // ------------------------------------------------------------------------
    // stall pattern and byte log
    // ------------------------------------------------------------------------
    logic [8:0] got[$];        // logged {last, byte} in arrival order
    logic       ph_r = 1'b0;   // stall phase, flips every cycle

    // ready always, or on alternate cycles to stress the hold of pkt outputs
    assign pkt_ready = !slow || ph_r;

    // log every byte taken at this edge
    always @(posedge ref_clk)
    begin
        ph_r <= !ph_r;
        if (pkt_valid && pkt_ready)
            got.push_back({pkt_last, pkt_data});
    end
endmodule

// >>> bench/serial_rx_packet_framer_tb.sv
// self-checking bench for the serial receive packet framer
// assumes srpf_map.svh on the include path; short ms for fast idle timing
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module serial_rx_packet_framer_tb;
    // ------------------------------------------------------------------------
    // stimulus signals
    // ------------------------------------------------------------------------
    logic ref_clk, srst, rx_valid, rx_ready, m1e, m2e, pkt_valid, pkt_last, pkt_ready;
    logic link_up, ll_high, ll_dtr, rts_req, dtr_req, rts_out, dtr_out, slow;
    logic [7:0]              rx_data, m1v, m2v, pkt_data;
    logic [10:0]             size_limit;
    logic [15:0]             idle_ms;
    srpf_pkg::srpf_policy_t  pol;
    logic [8:0]              exp[$];   // expected {last, byte} stream
    int                      failures = 0;
    int                      checked  = 0;

    srpf_framer #(.DEPTH(8), .MS_CYCLES(10)) dut_u (
        .ref_clk(ref_clk), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .size_limit(size_limit), .match1_en(m1e),
        .match1_val(m1v), .match2_en(m2e), .match2_val(m2v), .match_policy(pol),
        .idle_timeout_ms(idle_ms), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
        .pkt_last(pkt_last), .pkt_ready(pkt_ready), .link_up(link_up),
        .linkloss_high(ll_high), .linkloss_sel_dtr(ll_dtr), .rts_req(rts_req),
        .dtr_req(dtr_req), .rts_out(rts_out), .dtr_out(dtr_out));

    srpf_net_sink sink_u (.ref_clk(ref_clk), .slow(slow), .pkt_valid(pkt_valid),
        .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready));

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic results();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // offer one byte and hold it until the edge that takes it; valid stays up
    task automatic send(input logic [7:0] b);
        int i;
        rx_data  = b;
        rx_valid = 1'b1;
        for (i = 0; i < 400 && rx_ready !== 1'b1; i++)
            @(posedge ref_clk) #1;
        if (i == 400)
        begin
            failures++;
            results();
        end
        @(posedge ref_clk) #1;
    endtask

    // send a list back to back, then release valid
    task automatic burst(input logic [7:0] b[$]);
        foreach (b[i])
            send(b[i]);
        rx_valid = 1'b0;
    endtask

    // let packets drain, then compare the logged stream with the expected one
    task automatic drain(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
        `CHK(sink_u.got.size(), exp.size())
        foreach (exp[i])
            `CHK(sink_u.got[i], exp[i])
        sink_u.got.delete();
        exp.delete();
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    // limit 3 closes at the third byte; strip policy is inert with match off
    task automatic t_size();
        `CHK({rx_ready, pkt_valid, rts_out, dtr_out}, 4'hb)
        size_limit = 11'h003; pol = srpf_pkg::SRPF_STRIP; m1v = 8'h22;
        burst('{8'h11, 8'h22, 8'h33});
        `CHK(rx_ready, 1'b0)
        exp = '{9'h011, 9'h022, 9'h133};
        drain(40);
    endtask

    // no limit, no timeout: a partial buffer waits, a full one closes
    task automatic t_full();
        size_limit = 11'h000; slow = 1'b1;
        burst('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07});
        drain(300);
        burst('{8'h08});
        exp = '{9'h001, 9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h007, 9'h108};
        drain(60);
        slow = 1'b0;
    endtask

    // every policy on one delimiter, remainder flushed by the 1 ms idle timer
    task automatic t_match();
        m1e = 1'b1; m1v = 8'h0d; idle_ms = 16'h0001;
        size_limit = 11'h000; // size stays off while matching
        for (int p = 0; p < 4; p++)
        begin
            pol = srpf_pkg::srpf_policy_t'(p);
            burst('{8'ha1, 8'h0d, 8'hb2, 8'hc3});
            case (p)
                0: exp = '{9'h0a1, 9'h10d, 9'h0b2, 9'h1c3};
                1: exp = '{9'h0a1, 9'h00d, 9'h1b2, 9'h1c3};
                2: exp = '{9'h0a1, 9'h00d, 9'h0b2, 9'h1c3};
                default: exp = '{9'h1a1, 9'h0b2, 9'h1c3};
            endcase
            drain(80);
        end
    endtask

    // pair of delimiters: a lone first one does not close
    task automatic t_dual();
        pol = srpf_pkg::SRPF_KEEP; m2e = 1'b1; m2v = 8'h0a;
        burst('{8'h0d, 8'h55, 8'h0d, 8'h0a, 8'h66});
        exp = '{9'h00d, 9'h055, 9'h00d, 9'h10a, 9'h166};
        drain(80);
        pol = srpf_pkg::SRPF_STRIP;
        burst('{8'h77, 8'h0d, 8'h0a, 8'h88});
        exp = '{9'h177, 9'h188};
        drain(80);
        m1e = 1'b0; m2e = 1'b0;
    endtask

    // bytes 16 cycles apart under a 20 cycle timeout stay in one packet
    task automatic t_gap();
        idle_ms = 16'h0002; // 20 cycles, longer than the byte spacing
        for (int i = 0; i < 3; i++)
        begin
            burst('{8'h70 + 8'(i)});
            repeat (15) @(posedge ref_clk);
            #1;
        end
        exp = '{9'h070, 9'h071, 9'h172};
        drain(100);
    endtask

    // link loss forces the selected line to the policy level, other follows
    task automatic t_link();
        for (int k = 0; k < 4; k++)
        begin
            ll_high = k[0]; ll_dtr = k[1]; rts_req = !k[0]; dtr_req = !k[0];
            link_up = 1'b0;
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK(ll_dtr ? dtr_out : rts_out, ll_high)
            `CHK(ll_dtr ? rts_out : dtr_out, rts_req)
            link_up = 1'b1;
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK({rts_out, dtr_out}, {rts_req, dtr_req})
        end
    endtask

    // ------------------------------------------------------------------------
    // clock, reset and main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial
    begin
        srst = 1'b1; rx_valid = 1'b0; rx_data = 8'h00; size_limit = 11'h000;
        m1e = 1'b0; m1v = 8'h00; m2e = 1'b0; m2v = 8'h00; pol = srpf_pkg::SRPF_KEEP;
        idle_ms = 16'h0000; link_up = 1'b1; ll_high = 1'b1; ll_dtr = 1'b0;
        rts_req = 1'b1; dtr_req = 1'b1; slow = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        t_size();
        t_full();
        t_match();
        t_dual();
        t_gap();
        t_link();
        results();
    end
endmodule
